// ### design/sfw_pkg.sv
// Purpose: Shared constants for the software fault supervision timer
// Assumes: 40 MHz core clock, AXI4-Lite register access
// Notes: One control register, one aligned word
package sfw_pkg;
    // ********************************
    // Register map
    // ********************************
    localparam logic [3:0] SFW_CTRL_ADDR = 4'h0;
    localparam logic [7:0] SFW_CTRL_RESET = 8'h7F;
    localparam int SFW_ENABLE_BIT = 7;
    localparam int SFW_MSB_BIT = 6;
    localparam int SFW_CNT_WIDTH = 7;
    // ********************************
    // Timing
    // ********************************
    localparam int SFW_PRESCALE_CYCLES = 16384;
    localparam int SFW_CLK_MHZ = 40;
    localparam int SFW_RST_PULSE_US = 30;
    localparam int SFW_RST_PULSE_CYCLES = SFW_RST_PULSE_US * SFW_CLK_MHZ;
    // ********************************
    // AXI responses
    // ********************************
    localparam logic [1:0] SFW_RESP_OKAY = 2'h0;
    localparam logic [1:0] SFW_RESP_SLVERR = 2'h2;
endpackage

// ### design/sfw_prescaler.sv
// Purpose: Free-running divider giving one-cycle tick enables
// Assumes: Single clock, synchronous active-high reset
// Notes: Never cleared by register writes
`timescale 1ns/100ps
module sfw_prescaler
#(
    parameter int DIVIDE = 16384
)
(
    input wire logic core_clk,
    input wire logic rst,
    output logic tick
);
    localparam int CW = $clog2(DIVIDE);
    localparam logic [CW-1:0] LAST = CW'(DIVIDE - 1);
    logic [CW-1:0] count_ff;
    logic [CW-1:0] nxt_count;
    logic wrapNow;

    assign wrapNow = (count_ff == LAST);
    assign nxt_count = wrapNow ? '0 : count_ff + CW'(1);

    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            count_ff <= '0;
            tick <= 1'b0;
        end
        else
        begin
            count_ff <= nxt_count;
            tick <= wrapNow;
        end
    end
endmodule

// ### design/sfw_top.sv
// Purpose: Software fault supervision timer with AXI4-Lite control register
// Assumes: 40 MHz core_clk; option bits static straps; haltRequest same clock
// Notes: resetOut_n is held low for the pulse time, then released
//
// The implementer's own choices: the AXI4-Lite register port and the placing of the registers.
`timescale 1ns/100ps

// What this block does
// - Reset the system when the period ends without a software reload.
// - Seven-bit counter decrements once every 16384 clock cycles.
// - Low six counter bits give 64 selectable timeout lengths.
// - Enabled and counter passing 40h to 3Fh starts a reset.
// - Reset pulse holds the reset output low about 30 microseconds.
// - Counter keeps counting while disabled; only the reset is suppressed.
// - Any reset clears the enable bit.
// - Writes cannot clear the enable once set; only reset can.
// - Writing enable set with bit 6 clear resets at once.
// - Halt request while active produces a reset instead.
// - Timeout varies because writes do not realign the prescaler.
// - An option bit decides whether halt causes a reset.
// - An option bit selects always-active hardware mode.
// - In hardware mode the enable bit has no effect.
// - Control register reads 7Fh after reset.
module sfw_top
    import sfw_pkg::*;
#(
    parameter int PRESCALE = SFW_PRESCALE_CYCLES,
    parameter int PULSE_CYCLES = SFW_RST_PULSE_CYCLES
)
(
    input wire logic core_clk,
    input wire logic rst,
    input wire logic [3:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [3:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic haltRequest,
    input wire logic optHardwareMode,
    input wire logic optHaltReset,
    output logic resetOut_n,
    output logic haltGranted
);
    // ********************************
    // Declarations
    // ********************************
    typedef enum logic [1:0] {SFW_IDLE, SFW_PULSE} sfw_state_e;
    localparam int PW = $clog2(PULSE_CYCLES + 1);

    sfw_state_e state_ff;
    sfw_state_e nxt_state;
    logic [PW-1:0] pulseCnt_ff;
    logic [PW-1:0] nxt_pulseCnt;
    logic enable_ff;
    logic [SFW_CNT_WIDTH-1:0] count_ff;
    logic [SFW_CNT_WIDTH-1:0] nxt_count;
    logic nxt_enable;
    logic tick;
    logic hwSync1_ff;
    logic hwSync2_ff;
    logic hlSync1_ff;
    logic hlSync2_ff;
    logic awHeld_ff;
    logic wHeld_ff;
    logic [3:0] awAddr_ff;
    logic [7:0] wByte_ff;
    logic wLane_ff;
    logic arHit;
    logic doWrite;
    logic ctrlWrite;
    logic active;
    logic expire;
    logic swReset;
    logic haltReset;
    logic fire;
    logic nxt_resetOut_n;

    // ********************************
    // Prescaler
    // ********************************
    // Free running so writes land at an unknown phase
    sfw_prescaler #(.DIVIDE(PRESCALE)) u_presc
    (
        .core_clk(core_clk),
        .rst(rst),
        .tick(tick)
    );

    // ********************************
    // Option straps
    // ********************************
    always_ff @(posedge core_clk)
    begin
        hwSync1_ff <= optHardwareMode;
        hwSync2_ff <= hwSync1_ff;
        hlSync1_ff <= optHaltReset;
        hlSync2_ff <= hlSync1_ff;
    end

    // ********************************
    // Bus write path
    // ********************************
    assign doWrite = awHeld_ff && wHeld_ff && !s_axi_bvalid;
    assign ctrlWrite = doWrite && (awAddr_ff[3:2] == SFW_CTRL_ADDR[3:2])
        && wLane_ff;

    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            awHeld_ff <= 1'b0;
            wHeld_ff <= 1'b0;
            awAddr_ff <= 4'h0;
            wByte_ff <= 8'h00;
            wLane_ff <= 1'b0;
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= SFW_RESP_OKAY;
        end
        else
        begin
            s_axi_awready <= !awHeld_ff && !s_axi_awready && s_axi_awvalid;
            s_axi_wready <= !wHeld_ff && !s_axi_wready && s_axi_wvalid;
            if (s_axi_awvalid && s_axi_awready)
            begin
                awHeld_ff <= 1'b1;
                awAddr_ff <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready)
            begin
                wHeld_ff <= 1'b1;
                wByte_ff <= s_axi_wdata[7:0];
                wLane_ff <= s_axi_wstrb[0];
            end
            if (doWrite)
            begin
                awHeld_ff <= 1'b0;
                wHeld_ff <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= (awAddr_ff[3:2] == SFW_CTRL_ADDR[3:2])
                    ? SFW_RESP_OKAY : SFW_RESP_SLVERR;
            end
            else if (s_axi_bvalid && s_axi_bready)
            begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // ********************************
    // Bus read path
    // ********************************
    assign arHit = (s_axi_araddr[3:2] == SFW_CTRL_ADDR[3:2]);

    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= SFW_RESP_OKAY;
        end
        else
        begin
            s_axi_arready <= !s_axi_arready && !s_axi_rvalid
                && s_axi_arvalid;
            if (s_axi_arvalid && s_axi_arready)
            begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata <= arHit ? {24'h000000, enable_ff, count_ff}
                    : 32'h0000_0000;
                s_axi_rresp <= arHit ? SFW_RESP_OKAY : SFW_RESP_SLVERR;
            end
            else if (s_axi_rvalid && s_axi_rready)
            begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    // ********************************
    // Counter and enable
    // ********************************
    // Enable is sticky: a written zero is ignored
    assign nxt_enable = enable_ff
        || (ctrlWrite && wByte_ff[SFW_ENABLE_BIT]);
    // Write wins over a tick in the same cycle, reload is the refresh
    assign nxt_count = ctrlWrite ? wByte_ff[SFW_CNT_WIDTH-1:0]
        : tick ? count_ff - 7'h01 : count_ff;
    // Hardware mode makes the enable bit irrelevant
    assign active = enable_ff || hwSync2_ff;
    assign expire = active && tick && !ctrlWrite
        && (count_ff == 7'h40);
    assign swReset = ctrlWrite && (wByte_ff[SFW_ENABLE_BIT] || active)
        && !wByte_ff[SFW_MSB_BIT];
    assign haltReset = active && hlSync2_ff && haltRequest;
    assign fire = (state_ff == SFW_IDLE) && (expire || swReset || haltReset);

    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            enable_ff <= SFW_CTRL_RESET[SFW_ENABLE_BIT];
            count_ff <= SFW_CTRL_RESET[SFW_CNT_WIDTH-1:0];
        end
        else
        begin
            enable_ff <= nxt_enable;
            count_ff <= nxt_count;
        end
    end

    // ********************************
    // Reset pulse generator
    // ********************************
    always_comb
    begin
        nxt_state = state_ff;
        nxt_pulseCnt = pulseCnt_ff;
        nxt_resetOut_n = 1'b1;
        case (state_ff)
            SFW_IDLE:
            begin
                if (fire)
                begin
                    nxt_state = SFW_PULSE;
                    nxt_pulseCnt = PW'(PULSE_CYCLES - 1);
                    nxt_resetOut_n = 1'b0;
                end
            end
            SFW_PULSE:
            begin
                if (pulseCnt_ff == '0)
                begin
                    nxt_state = SFW_IDLE;
                end
                else
                begin
                    nxt_pulseCnt = pulseCnt_ff - PW'(1);
                    nxt_resetOut_n = 1'b0;
                end
            end
            default:
            begin
                nxt_state = SFW_IDLE;
            end
        endcase
    end

    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            state_ff <= SFW_IDLE;
            pulseCnt_ff <= '0;
            resetOut_n <= 1'b1;
            haltGranted <= 1'b0;
        end
        else
        begin
            state_ff <= nxt_state;
            pulseCnt_ff <= nxt_pulseCnt;
            resetOut_n <= nxt_resetOut_n;
            // Halt proceeds only when it is not turned into a reset
            haltGranted <= haltRequest && !haltReset;
        end
    end

    // ********************************
    // Checks
    // ********************************
    a_pulse_width: assert property (
        @(posedge core_clk) disable iff (rst)
        $fell(resetOut_n) |-> !resetOut_n [*8])
        else $error("reset pulse too short");
    a_expire_fires: assert property (
        @(posedge core_clk) disable iff (rst)
        (state_ff == SFW_IDLE && expire) |=> !resetOut_n)
        else $error("expiry did not drive reset");
    a_enable_sticky: assert property (
        @(posedge core_clk) disable iff (rst)
        enable_ff |=> enable_ff)
        else $error("enable cleared by write");
    a_count_step: assert property (
        @(posedge core_clk) disable iff (rst)
        (tick && !ctrlWrite) |=> count_ff == $past(count_ff) - 7'h01)
        else $error("counter did not decrement");
    a_disabled_quiet: assert property (
        @(posedge core_clk) disable iff (rst)
        (!active && !ctrlWrite && state_ff == SFW_IDLE) |=> resetOut_n)
        else $error("reset while disabled");
    a_sw_reset: assert property (
        @(posedge core_clk) disable iff (rst)
        (state_ff == SFW_IDLE && swReset) |=> !resetOut_n)
        else $error("software reset missing");
    a_halt_reset: assert property (
        @(posedge core_clk) disable iff (rst)
        (state_ff == SFW_IDLE && haltReset) |=> !resetOut_n ##0 !haltGranted)
        else $error("halt did not reset");
    a_write_reload: assert property (
        @(posedge core_clk) disable iff (rst)
        ctrlWrite |=> count_ff == $past(wByte_ff[6:0]))
        else $error("write did not reload counter");
endmodule

// ### dv/sfw_top_bench.sv
// Purpose: Self-checking bench for the supervision timer
// Assumes: Prescale shortened to 16, reset pulse to 8 cycles
// Notes: Random counts and refresh gaps come from a fixed seed
`timescale 1ns/100ps
`define CHK(g, e) \
    begin \
        num_checks++; \
        if ((g) !== (e)) \
        begin \
            failures++; \
            $display("[FAIL] t=%0t got=%0h exp=%0h", $time, g, e); \
        end \
    end
module sfw_top_bench
    import sfw_pkg::*;
;
    localparam int PS = 16;
    localparam int PW = 8;
    logic core_clk = 1'h0;
    logic rst = 1'h1;
    logic [3:0] awAddr = 4'h0;
    logic [3:0] arAddr = 4'h0;
    logic [31:0] wData = 32'h0;
    logic awValid = 1'h0;
    logic wValid = 1'h0;
    logic bReady = 1'h0;
    logic arValid = 1'h0;
    logic rReady = 1'h0;
    logic haltRequest = 1'h0;
    logic optHardwareMode = 1'h0;
    logic optHaltReset = 1'h0;
    logic [3:0] wStrb = 4'hF;
    logic awReady, wReady, bValid, arReady, rValid, resetOut_n, haltGranted;
    logic [1:0] bResp, rResp;
    logic [31:0] rData;
    int failures = 0;
    int num_checks = 0;
    int pulses = 0;
    sfw_top #(.PRESCALE(PS), .PULSE_CYCLES(PW)) i_sfw_top (
        .core_clk(core_clk), .rst(rst),
        .s_axi_awaddr(awAddr), .s_axi_awvalid(awValid),
        .s_axi_awready(awReady), .s_axi_wdata(wData),
        .s_axi_wstrb(wStrb), .s_axi_wvalid(wValid), .s_axi_wready(wReady),
        .s_axi_bresp(bResp), .s_axi_bvalid(bValid), .s_axi_bready(bReady),
        .s_axi_araddr(arAddr), .s_axi_arvalid(arValid),
        .s_axi_arready(arReady), .s_axi_rdata(rData),
        .s_axi_rresp(rResp), .s_axi_rvalid(rValid), .s_axi_rready(rReady),
        .haltRequest(haltRequest), .optHardwareMode(optHardwareMode),
        .optHaltReset(optHaltReset), .resetOut_n(resetOut_n),
        .haltGranted(haltGranted));
    initial forever #12.5 core_clk = ~core_clk;
    always @(negedge resetOut_n) pulses++;
    // ********************************
    // Bus and timing helpers
    // ********************************
    task automatic do_reset();
        @(posedge core_clk);
        rst <= 1'h1;
        repeat (4) @(posedge core_clk);
        rst <= 1'h0;
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] d,
                      output logic [1:0] r);
        bit aw;
        bit w;
        @(posedge core_clk);
        awAddr <= a;
        wData <= {24'h0, d};
        awValid <= 1'h1;
        wValid <= 1'h1;
        bReady <= 1'h1;
        aw = 0;
        w = 0;
        while (!(aw && w))
        begin
            @(posedge core_clk);
            if (awValid && awReady === 1'h1) aw = 1;
            if (wValid && wReady === 1'h1) w = 1;
            if (aw) awValid <= 1'h0;
            if (w) wValid <= 1'h0;
        end
        while (bValid !== 1'h1) @(posedge core_clk);
        r = bResp;
        bReady <= 1'h0;
    endtask
    task automatic rd(input logic [3:0] a, output logic [31:0] d,
                      output logic [1:0] r);
        @(posedge core_clk);
        arAddr <= a;
        arValid <= 1'h1;
        rReady <= 1'h1;
        do @(posedge core_clk); while (arReady !== 1'h1);
        arValid <= 1'h0;
        while (rValid !== 1'h1) @(posedge core_clk);
        d = rData;
        r = rResp;
        rReady <= 1'h0;
    endtask
    // Stops early only when the reset output goes low
    task automatic wait_low(input int lim, output int n);
        n = 0;
        do
        begin
            @(posedge core_clk);
            n++;
        end
        while (resetOut_n !== 1'h0 && n < lim);
    endtask
    task automatic pulse_len(output int n);
        n = 1;
        @(posedge core_clk);
        while (resetOut_n === 1'h0)
        begin
            n++;
            @(posedge core_clk);
        end
    endtask
    // Prescaler phase is unknown at the write, so allow a whole tick
    function automatic int exp_lo(input int n);
        return n * PS;
    endfunction
    function automatic int exp_hi(input int n);
        return (n + 1) * PS + 4;
    endfunction
    task automatic done_test(input string s);
        $display("Test %s ended: checks=%0d failures=%0d", s, num_checks,
                 failures);
    endtask
    task automatic give_verdict();
        $display("Counts: checks=%0d failures=%0d", num_checks, failures);
        if (failures == 0 && num_checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    initial
    begin
        repeat (20000) @(posedge core_clk);
        failures++;
        give_verdict();
    end
    // ********************************
    // Tests
    // ********************************
    initial
    begin
        logic [31:0] d;
        logic [1:0] r;
        logic [6:0] c0;
        logic [5:0] n;
        int t;
        int p;
        void'($urandom(88));
        repeat (4) @(posedge core_clk);
        rst <= 1'h0;
        rd(SFW_CTRL_ADDR, d, r);
        `CHK(d, {24'h0, SFW_CTRL_RESET});
        `CHK(r, SFW_RESP_OKAY);
        rd(4'h4, d, r);
        `CHK({r, d}, {SFW_RESP_SLVERR, 32'h0});
        wr(4'h8, 8'hC0, r);
        `CHK(r, SFW_RESP_SLVERR);
        // Byte lane off: write must be dropped, no reset
        wStrb <= 4'h0;
        wr(SFW_CTRL_ADDR, 8'h80, r);
        wStrb <= 4'hF;
        `CHK({r, resetOut_n}, {SFW_RESP_OKAY, 1'h1});
        done_test("map");
        rd(SFW_CTRL_ADDR, d, r);
        c0 = d[6:0];
        repeat (10 * PS) @(posedge core_clk);
        rd(SFW_CTRL_ADDR, d, r);
        c0 = c0 - d[6:0];
        `CHK(c0 >= 7'h9 && c0 <= 7'hB, 1'h1);
        `CHK(d[7], 1'h0);
        wait_low(80 * PS, t);
        `CHK(resetOut_n, 1'h1);
        done_test("free_run");
        for (int k = 0; k < 4; k++)
        begin
            n = (k == 0) ? 6'h0 : (k == 1) ? 6'h3F : 6'($urandom_range(1, 62));
            do_reset();
            wr(SFW_CTRL_ADDR, {2'h3, n}, r);
            wait_low(exp_hi(n) + 1, t);
            `CHK(t >= exp_lo(n), 1'h1);
            `CHK(t <= exp_hi(n), 1'h1);
            pulse_len(p);
            `CHK(p, PW);
        end
        done_test("expiry");
        do_reset();
        p = pulses;
        for (int k = 0; k < 8; k++)
        begin
            wr(SFW_CTRL_ADDR, 8'hC3, r);
            repeat ($urandom_range(PS, 2 * PS)) @(posedge core_clk);
        end
        wr(SFW_CTRL_ADDR, 8'h7F, r);
        rd(SFW_CTRL_ADDR, d, r);
        `CHK(d[7], 1'h1);
        `CHK(pulses - p, 0);
        done_test("refresh");
        do_reset();
        wr(SFW_CTRL_ADDR, 8'h80, r);
        wait_low(6, t);
        `CHK({r, resetOut_n}, {SFW_RESP_OKAY, 1'h0});
        done_test("soft_reset");
        for (int k = 0; k < 4; k++)
        begin
            optHaltReset <= k[0];
            do_reset();
            if (k[1]) wr(SFW_CTRL_ADDR, 8'hFF, r);
            p = pulses;
            haltRequest <= 1'h1;
            repeat (2) @(posedge core_clk);
            `CHK(haltGranted, !(k[0] && k[1]));
            repeat (3) @(posedge core_clk);
            haltRequest <= 1'h0;
            `CHK(pulses - p, int'(k[0] && k[1]));
        end
        done_test("halt");
        optHardwareMode <= 1'h1;
        do_reset();
        wr(SFW_CTRL_ADDR, 8'h7F, r);
        wait_low(65 * PS + 4, t);
        `CHK(resetOut_n, 1'h0);
        optHardwareMode <= 1'h0;
        done_test("hw_mode");
        give_verdict();
    end
endmodule
